// File: logic/tsm_ctrl.sv
// Top of the touch sleep-sampling, pin interrupt enable and multi-touch blocking slice
`timescale 1ns/100ps
module tsm_ctrl
(
	input wire logic mclk,
	input wire logic rst,
	input tsm_pkg::tsm_reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	input wire logic [tsm_pkg::TSM_PIN_W-1:0] pin_status,
	input wire logic sleep_state,
	input wire logic meas_done,
	input tsm_pkg::tsm_sense_s sense,
	output logic irq,
	output logic [tsm_pkg::TSM_SENS_W-1:0] btn_sample_en,
	output logic grp_sample_en,
	output logic [tsm_pkg::TSM_SENS_W-1:0] btn_status_set,
	output logic [tsm_pkg::TSM_GEST_W-1:0] grp_status_set,
	output logic settle_extended,
	output logic [tsm_pkg::TSM_SENS_W-1:0] btn_accepted,
	output logic [tsm_pkg::TSM_SENS_W-1:0] grp_accepted,
	output logic btn_multi_event,
	output logic grp_multi_event
);
	import tsm_pkg::*;

	// ****************************************
	// State
	// ****************************************
	tsm_top_s st_q;
	tsm_top_s st_d;

	logic [TSM_CNT_W-1:0] btn_limit;
	logic [TSM_CNT_W-1:0] grp_limit;

	assign btn_limit = tsm_btn_limit(st_q.mt_btn_code);
	assign grp_limit = tsm_grp_limit(st_q.mt_grp_code);

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		logic [7:0] new_mask;
		logic [7:0] rise;
		new_mask = st_q.sleep_mask;
		rise = '0;
		st_d = st_q;

		// Register writes
		if (reg_req.wr)
		begin
			case (reg_req.addr)
				TSM_ADDR_PIN_IRQ_EN: st_d.pin_irq_en = reg_req.wdata;
				TSM_ADDR_SLEEP_MASK:
				begin
					st_d.sleep_mask = reg_req.wdata;
					new_mask = reg_req.wdata;
				end
				TSM_ADDR_MT_CFG:
				begin
					// Bits 6..4 are not stored, so they cannot be written
					st_d.mt_blk_en = reg_req.wdata[TSM_MT_BLK_BIT];
					st_d.mt_btn_code = reg_req.wdata[TSM_MT_BTN_LSB +: 2];
					st_d.mt_grp_code = reg_req.wdata[TSM_MT_GRP_LSB +: 2];
				end
				default: ;
			endcase
		end

		// Register reads, answered one cycle later
		if (reg_req.rd)
		begin
			case (reg_req.addr)
				TSM_ADDR_PIN_IRQ_EN: st_d.rdata = st_q.pin_irq_en;
				TSM_ADDR_SLEEP_MASK: st_d.rdata = st_q.sleep_mask;
				TSM_ADDR_MT_CFG: st_d.rdata = {st_q.mt_blk_en, 3'h0, st_q.mt_btn_code, st_q.mt_grp_code};
				default: st_d.rdata = TSM_UNMAPPED_DATA;
			endcase
		end

		// Sleep sampling: outside Sleep every channel runs normally
		if (sleep_state)
		begin
			st_d.btn_sample = st_q.sleep_mask[TSM_SENS_W-1:0];
			st_d.grp_sample = st_q.sleep_mask[TSM_SLEEP_GROUP_BIT];
		end
		else
		begin
			st_d.btn_sample = '1;
			st_d.grp_sample = 1'b1;
		end

		// Sleep wake events only from channels that are being sampled
		st_d.btn_prev = sense.btn_touch;
		if (sleep_state)
		begin
			st_d.btn_set = sense.btn_touch & ~st_q.btn_prev & st_q.btn_sample;
			st_d.grp_set = sense.grp_gesture & {TSM_GEST_W{st_q.grp_sample}};
		end
		else
		begin
			st_d.btn_set = '0;
			st_d.grp_set = '0;
		end

		// Channels switched on during Sleep owe one longer conversion; the set wins over meas_done
		if (sleep_state)
		begin
			rise = new_mask & ~st_q.sleep_mask;
		end
		if (meas_done)
		begin
			st_d.settle_pend = rise;
		end
		else
		begin
			st_d.settle_pend = st_q.settle_pend | rise;
		end
		st_d.settle = |st_d.settle_pend;

		// Interrupt: enabled pin status plus sleep wake events
		st_d.irq = (|(pin_status & st_q.pin_irq_en)) | (|st_d.btn_set) | (|st_d.grp_set);
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= '0;
			st_q.pin_irq_en <= TSM_RST_PIN_IRQ_EN;
			st_q.sleep_mask <= TSM_RST_SLEEP_MASK;
			st_q.mt_blk_en <= TSM_RST_MT_CFG[TSM_MT_BLK_BIT];
			st_q.mt_btn_code <= TSM_RST_MT_CFG[TSM_MT_BTN_LSB +: 2];
			st_q.mt_grp_code <= TSM_RST_MT_CFG[TSM_MT_GRP_LSB +: 2];
			st_q.btn_sample <= '1;
			st_q.grp_sample <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Multi-touch blocking, buttons and group each against own limit
	// ****************************************
	tsm_blocker u_btn_blk
	(
		.mclk(mclk),
		.rst(rst),
		.touch(sense.btn_touch),
		.blk_en(st_q.mt_blk_en),
		.limit(btn_limit),
		.accepted(btn_accepted),
		.multi_event(btn_multi_event)
	);

	tsm_blocker u_grp_blk
	(
		.mclk(mclk),
		.rst(rst),
		.touch(sense.grp_touch),
		.blk_en(st_q.mt_blk_en),
		.limit(grp_limit),
		.accepted(grp_accepted),
		.multi_event(grp_multi_event)
	);

	assign reg_rdata = st_q.rdata;
	assign irq = st_q.irq;
	assign btn_sample_en = st_q.btn_sample;
	assign grp_sample_en = st_q.grp_sample;
	assign btn_status_set = st_q.btn_set;
	assign grp_status_set = st_q.grp_set;
	assign settle_extended = st_q.settle;

endmodule : tsm_ctrl

// File: logic/tsm_pkg.sv
// Package of constants, register map and carrier types for the touch sleep / multi-touch control slice
//
// Contract
// - Pin status bit set with its enable at one drives the interrupt; pin n is bit n-1.
// - Pin status with enable zero never asserts the interrupt; pin 8 enable resets to zero.
// - Sleep mask selects sensors sampled in Sleep; resets to zero, nothing sampled.
// - Group sleep bit 7 samples the group in Sleep; gestures set status and interrupt.
// - Sleep mask bits 6..0 sample buttons 7..1 in Sleep; touch sets status and interrupt.
// - A cleared sleep mask bit stops sampling of that button or the group in Sleep.
// - Mask change in Sleep may lengthen the first cycle; later cycles return to normal.
// - Blocking enable bit 7 at zero accepts all simultaneous touches.
// - With blocking, accept up to the limit, block others until the valid ones release.
// - Button limit field bits 3:2 decodes 00..11 as 1, 2, 3, 4 touches.
// - Group limit field bits 1:0 decodes 00..11 as 2, 3, 4, 1 touches.
// - Multiple touch event only when count exceeds its own limit; buttons and group apart.
// - Multi-touch configuration reads 82h after reset.
package tsm_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] TSM_ADDR_PIN_IRQ_EN = 8'h28;
	localparam logic [7:0] TSM_ADDR_SLEEP_MASK = 8'h29;
	localparam logic [7:0] TSM_ADDR_MT_CFG = 8'h2A;

	localparam logic [7:0] TSM_RST_PIN_IRQ_EN = 8'h00;
	localparam logic [7:0] TSM_RST_SLEEP_MASK = 8'h00;
	localparam logic [7:0] TSM_RST_MT_CFG = 8'h82;
	localparam logic [7:0] TSM_UNMAPPED_DATA = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int TSM_SLEEP_GROUP_BIT = 7;
	localparam int TSM_MT_BLK_BIT = 7;
	localparam int TSM_MT_BTN_LSB = 2;
	localparam int TSM_MT_GRP_LSB = 0;

	localparam int TSM_SENS_W = 7;
	localparam int TSM_PIN_W = 8;
	localparam int TSM_GEST_W = 3;
	localparam int TSM_CNT_W = 3;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tsm_reg_req_s;

	typedef struct packed {
		logic [TSM_SENS_W-1:0] btn_touch;
		logic [TSM_SENS_W-1:0] grp_touch;
		logic [TSM_GEST_W-1:0] grp_gesture;
	} tsm_sense_s;

	typedef struct packed {
		logic [TSM_SENS_W-1:0] accepted;
		logic multi_event;
	} tsm_blk_s;

	typedef struct packed {
		logic [TSM_PIN_W-1:0] pin_irq_en;
		logic [7:0] sleep_mask;
		logic mt_blk_en;
		logic [1:0] mt_btn_code;
		logic [1:0] mt_grp_code;
		logic [7:0] rdata;
		logic irq;
		logic [TSM_SENS_W-1:0] btn_sample;
		logic grp_sample;
		logic [TSM_SENS_W-1:0] btn_prev;
		logic [TSM_SENS_W-1:0] btn_set;
		logic [TSM_GEST_W-1:0] grp_set;
		logic [7:0] settle_pend;
		logic settle;
	} tsm_top_s;

	// ****************************************
	// Decoders
	// ****************************************
	function automatic logic [TSM_CNT_W-1:0] tsm_btn_limit(input logic [1:0] code);
		tsm_btn_limit = {1'b0, code} + 3'h1;
	endfunction : tsm_btn_limit

	function automatic logic [TSM_CNT_W-1:0] tsm_grp_limit(input logic [1:0] code);
		case (code)
			2'h0: tsm_grp_limit = 3'h2;
			2'h1: tsm_grp_limit = 3'h3;
			2'h2: tsm_grp_limit = 3'h4;
			default: tsm_grp_limit = 3'h1;
		endcase
	endfunction : tsm_grp_limit

	function automatic logic [TSM_CNT_W-1:0] tsm_count(input logic [TSM_SENS_W-1:0] v);
		logic [TSM_CNT_W-1:0] n;
		n = 3'h0;
		for (int i = 0; i < TSM_SENS_W; i++)
		begin
			n = n + {2'h0, v[i]};
		end
		tsm_count = n;
	endfunction : tsm_count

endpackage : tsm_pkg

// File: logic/tsm_blocker.sv
// Multiple-touch blocker for one sensor set (buttons or group)
`timescale 1ns/100ps
module tsm_blocker
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [tsm_pkg::TSM_SENS_W-1:0] touch,
	input wire logic blk_en,
	input wire logic [tsm_pkg::TSM_CNT_W-1:0] limit,
	output logic [tsm_pkg::TSM_SENS_W-1:0] accepted,
	output logic multi_event
);
	import tsm_pkg::*;

	tsm_blk_s st_q;
	tsm_blk_s st_d;

	always_comb
	begin
		logic [TSM_SENS_W-1:0] keep;
		logic [TSM_CNT_W-1:0] n;
		keep = '0;
		n = '0;
		st_d = st_q;
		if (!blk_en)
		begin
			st_d.accepted = touch;
		end
		else
		begin
			// Held sensors stay valid; a new one gets in only while room remains
			keep = st_q.accepted & touch;
			n = tsm_count(keep);
			for (int i = 0; i < TSM_SENS_W; i++)
			begin
				if (touch[i] && !keep[i] && (n < limit))
				begin
					keep[i] = 1'b1;
					n = n + 3'h1;
				end
			end
			st_d.accepted = keep;
		end
		st_d.multi_event = (tsm_count(touch) > limit);
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign accepted = st_q.accepted;
	assign multi_event = st_q.multi_event;

endmodule : tsm_blocker

// File: dv/tsm_host.sv
// Host model driving the register strobes of the touch control slice
`timescale 1ns/100ps
module tsm_host
(
	input wire logic mclk,
	output tsm_pkg::tsm_reg_req_s reg_req
);
	import tsm_pkg::*;
	initial reg_req = '0;
	// Idle cycle after each access keeps strobes from being rewritten in one time step
	task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		reg_req = '{wr: w, rd: r, addr: a, wdata: d};
		@(posedge mclk);
		#1;
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		@(posedge mclk);
		#1;
	endtask : access
endmodule : tsm_host

// File: dv/tsm_ctrl_assertions.sv
// Port-level checker of the touch control slice
`timescale 1ns/100ps
module tsm_ctrl_assertions
import tsm_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input tsm_pkg::tsm_reg_req_s reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic [tsm_pkg::TSM_PIN_W-1:0] pin_status,
	input wire logic sleep_state,
	input tsm_pkg::tsm_sense_s sense,
	input wire logic irq,
	input wire logic [tsm_pkg::TSM_SENS_W-1:0] btn_sample_en,
	input wire logic grp_sample_en,
	input wire logic [tsm_pkg::TSM_SENS_W-1:0] btn_status_set,
	input wire logic [tsm_pkg::TSM_GEST_W-1:0] grp_status_set,
	input wire logic [tsm_pkg::TSM_SENS_W-1:0] btn_accepted,
	input wire logic grp_multi_event
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Shadow of the pin interrupt enable, rebuilt from the register bus
	logic [7:0] pin_en_q;
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pin_en_q <= TSM_RST_PIN_IRQ_EN;
		end
		else if (reg_req.wr && reg_req.addr == TSM_ADDR_PIN_IRQ_EN)
		begin
			pin_en_q <= reg_req.wdata;
		end
	end
	// Settled Sleep only: enables still show the awake value on the first Sleep cycle
	sequence s_btn_wake;
		sleep_state && $past(sleep_state) && |(btn_sample_en & sense.btn_touch & ~$past(sense.btn_touch));
	endsequence
	property p_irq_cause;
		irq |-> $past(|(pin_status & pin_en_q)) || |btn_status_set || |grp_status_set;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
	property p_irq_pin;
		|(pin_status & pin_en_q) |=> irq;
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("enabled pin status without irq");
	property p_btn_wake;
		s_btn_wake |=> |btn_status_set && irq;
	endproperty
	a_btn_wake: assert property (p_btn_wake) else $error("button wake missed");
	property p_btn_gate;
		(btn_status_set & ~$past(btn_sample_en)) == 7'h00;
	endproperty
	a_btn_gate: assert property (p_btn_gate) else $error("unsampled button set status");
	property p_grp_wake;
		sleep_state && $past(sleep_state) && grp_sample_en && |sense.grp_gesture |=>
			grp_status_set == $past(sense.grp_gesture);
	endproperty
	a_grp_wake: assert property (p_grp_wake) else $error("group wake missed");
	property p_awake_all;
		!sleep_state |=> btn_sample_en == 7'h7F && grp_sample_en;
	endproperty
	a_awake_all: assert property (p_awake_all) else $error("awake sampling off");
	property p_accept_sub;
		(btn_accepted & ~$past(sense.btn_touch)) == 7'h00;
	endproperty
	a_accept_sub: assert property (p_accept_sub) else $error("untouched button accepted");
	property p_multi_max;
		$countones(sense.grp_touch) > 4 |=> grp_multi_event;
	endproperty
	a_multi_max: assert property (p_multi_max) else $error("group multi event missed");
	property p_cfg_pad;
		reg_req.rd && reg_req.addr == TSM_ADDR_MT_CFG |=> reg_rdata[6:4] == 3'h0;
	endproperty
	a_cfg_pad: assert property (p_cfg_pad) else $error("config pad bits set");
endmodule : tsm_ctrl_assertions
bind tsm_ctrl tsm_ctrl_assertions u_tsm_ctrl_assertions
(
	.mclk(mclk),
	.rst(rst),
	.reg_req(reg_req),
	.reg_rdata(reg_rdata),
	.pin_status(pin_status),
	.sleep_state(sleep_state),
	.sense(sense),
	.irq(irq),
	.btn_sample_en(btn_sample_en),
	.grp_sample_en(grp_sample_en),
	.btn_status_set(btn_status_set),
	.grp_status_set(grp_status_set),
	.btn_accepted(btn_accepted),
	.grp_multi_event(grp_multi_event)
);

// File: dv/touch_sleep_multitouch_ctrl_bench.sv
// Self-checking bench of the touch control slice
`timescale 1ns/100ps
module touch_sleep_multitouch_ctrl_bench;
	import tsm_pkg::*;
	logic mclk = 0;
	logic rst = 1;
	logic [7:0] pin_status = 8'hFF;
	logic sleep_state = 0;
	logic meas_done = 0;
	tsm_sense_s sense = '0;
	tsm_reg_req_s reg_req;
	logic [7:0] reg_rdata, en, pin, exp_q[$];
	logic irq, grp_sample_en, settle_extended, btn_multi_event, grp_multi_event;
	logic rd_p = 0;
	logic [6:0] btn_sample_en, btn_status_set, btn_accepted, grp_accepted;
	logic [2:0] grp_status_set;
	int err_total = 0;
	int comparisons = 0;
	int bl, gl;
	integer seed = 32'h2f938fa6;
	tsm_host u_tsm_host
	(
		.mclk(mclk),
		.reg_req(reg_req)
	);
	tsm_ctrl u_tsm_ctrl
	(
		.mclk(mclk),
		.rst(rst),
		.reg_req(reg_req),
		.reg_rdata(reg_rdata),
		.pin_status(pin_status),
		.sleep_state(sleep_state),
		.meas_done(meas_done),
		.sense(sense),
		.irq(irq),
		.btn_sample_en(btn_sample_en),
		.grp_sample_en(grp_sample_en),
		.btn_status_set(btn_status_set),
		.grp_status_set(grp_status_set),
		.settle_extended(settle_extended),
		.btn_accepted(btn_accepted),
		.grp_accepted(grp_accepted),
		.btn_multi_event(btn_multi_event),
		.grp_multi_event(grp_multi_event)
	);
	initial forever #5 mclk = ~mclk;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_tsm_host.access(1'b0, 1'b1, a, 8'h00);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_tsm_host.access(1'b1, 1'b0, a, d);
	endtask : wr
	task automatic conclude;
		if (err_total == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	// ****
	// Read data watcher
	// ****
	always @(posedge mclk) rd_p <= reg_req.rd;
	always @(negedge mclk)
		if (rd_p && !rst)
			check(reg_rdata, exp_q.pop_front());
	initial
	begin
		repeat (20000) @(posedge mclk);
		err_total++;
		conclude();
	end
	initial
	begin
		tick(3);
		rst = 0;
		tick(2);
		check(8'(irq), 8'h00);
		rd(8'h28, 8'h00);
		rd(8'h29, 8'h00);
		rd(8'h2A, 8'h82);
		rd(8'h30, 8'h00);
		wr(8'h2A, 8'hFF);
		rd(8'h2A, 8'h8F);
		repeat (8)
		begin
			en = 8'($random(seed));
			pin = 8'($random(seed));
			pin_status = pin;
			wr(8'h28, en);
			check(8'(irq), {7'h00, |(en & pin)});
		end
		pin_status = 8'h00;
		for (int c = 0; c < 4; c++)
		begin
			bl = c + 1;
			gl = (c == 3) ? 1 : c + 2;
			wr(8'h2A, {4'h8, c[1:0], c[1:0]});
			sense.btn_touch = (7'h1 << bl) - 7'h1;
			sense.grp_touch = (7'h1 << gl) - 7'h1;
			tick(2);
			check(8'(btn_multi_event), 8'h00);
			check(8'(grp_multi_event), 8'h00);
			sense.btn_touch = 7'h7F;
			sense.grp_touch = (7'h1 << (gl + 1)) - 7'h1;
			tick(2);
			check(8'(btn_multi_event), 8'h01);
			check(8'(grp_multi_event), 8'h01);
			check(8'(btn_accepted), 8'((7'h1 << bl) - 7'h1));
			check(8'(grp_accepted), 8'((7'h1 << gl) - 7'h1));
			sense.btn_touch = 7'h7E;
			tick(2);
			check(8'(btn_accepted), 8'(((7'h1 << (bl + 1)) - 7'h1) & 7'h7E));
			wr(8'h2A, {4'h0, c[1:0], c[1:0]});
			tick(1);
			check(8'(btn_accepted), 8'h7E);
			sense = '0;
			tick(2);
		end
		wr(8'h29, 8'h81);
		sleep_state = 1;
		tick(2);
		check(8'(btn_sample_en), 8'h01);
		check(8'(grp_sample_en), 8'h01);
		sense.btn_touch = 7'h02;
		tick(2);
		check(8'(btn_status_set), 8'h00);
		sense.btn_touch = 7'h03;
		tick(1);
		check(8'(btn_status_set), 8'h01);
		check(8'(irq), 8'h01);
		sense.grp_gesture = 3'h4;
		tick(1);
		sense.grp_gesture = 3'h0;
		check(8'(btn_status_set), 8'h00);
		check(8'(grp_status_set), 8'h04);
		wr(8'h29, 8'h83);
		check(8'(settle_extended), 8'h01);
		// Host asks for recalibration of the newly enabled button; that register lives outside this slice
		wr(8'h26, 8'h02);
		meas_done = 1;
		tick(1);
		meas_done = 0;
		tick(1);
		check(8'(settle_extended), 8'h00);
		sleep_state = 0;
		tick(2);
		check(8'(btn_sample_en), 8'h7F);
		conclude();
	end
endmodule : touch_sleep_multitouch_ctrl_bench
